// ===== cmpc_ctrl.sv
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/10ps
`include "cmpc_defs.svh"
// How it works
// - mux feeds negative input only when enabled, converter off
// - channel field picks converter pin 0 to 7
// - disable bit powers comparator off anytime
// - bandgap bit replaces positive pin input
// - result bit is synchronized, one to two cycles late
// - flag set on event matching selected mode
// - flag cleared by vector or writing one
// - request needs flag, enable and global enable
// - capture bit routes result to timer capture
// - mode field: toggle, reserved, falling, rising
// - buffer-off bits kill pin buffer, read zero
// - result high when positive exceeds negative
// - converter enable blocks the mux path
module cmpc_ctrl
   import cmpc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cmp_raw,
   input  wire logic        converter_enable,
   input  wire logic        global_irq_enable,
   input  wire logic        irq_vector_ack,
   input  wire logic        pos_pin_digital,
   input  wire logic        neg_pin_digital,
   output logic             cmp_power_off,
   output logic             pos_bandgap_sel,
   output logic             neg_from_mux,
   output logic      [2:0]  neg_channel_sel,
   output logic             capture_in,
   output logic             cmp_irq_req,
   output logic             irq,
   output logic             pos_pin_buffer_off,
   output logic             neg_pin_buffer_off,
   output logic             pos_pin_read,
   output logic             neg_pin_read
);

   // byte lane bits 1:0 take no part in the decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a[7:2] == o[7:2]);
   endfunction

   // registers
   logic             dis_q, dis_d;
   logic             bg_q, bg_d;
   logic             flag_q, flag_d;
   logic             ie_q, ie_d;
   logic             cap_q, cap_d;
   cmpc_mode_e       mode_q, mode_d;
   logic             pos_off_q, pos_off_d;
   logic             neg_off_q, neg_off_d;
   logic             mux_en_q, mux_en_d;
   logic [2:0]       chan_q, chan_d;
   logic             stat_q, stat_d;
   logic             mask_q, mask_d;

   // comparator path
   logic             sync1_q;
   logic             sync2_q;
   logic             prev_q;
   logic             event_hit;

   // bus answer
   logic [31:0]      prdata_q, prdata_d;
   logic             pready_q, pready_d;
   logic             pslverr_q, pslverr_d;
   logic             wr_en;
   logic             rd_done;
   logic             mapped;
   cmpc_byte_t       rd_byte;

   // registered outputs
   logic             neg_mux_q, neg_mux_d;
   logic             capture_q, capture_d;
   logic             req_q, req_d;
   logic             irq_q, irq_d;
   logic             pos_rd_q, pos_rd_d;
   logic             neg_rd_q, neg_rd_d;

   // two-flop synchronizer; only sync2_q is looked at
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
      end else begin
         sync1_q <= cmp_raw;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // event decode against the mode in force now; reserved never fires
   always_comb begin
      case (mode_q)
         CMPC_TOGGLE: event_hit = sync2_q ^ prev_q;
         CMPC_FALL:   event_hit = prev_q & ~sync2_q;
         CMPC_RISE:   event_hit = ~prev_q & sync2_q;
         default:     event_hit = 1'b0;
      endcase
   end

   assign mapped  = hit(paddr, `CMPC_CSR_OFS)  |
                    hit(paddr, `CMPC_DIDR_OFS) |
                    hit(paddr, `CMPC_MUXC_OFS) |
                    hit(paddr, `CMPC_STAT_OFS) |
                    hit(paddr, `CMPC_MASK_OFS);
   assign wr_en   = psel & penable & pready_q & pwrite & pstrb[0] & mapped;
   assign rd_done = psel & penable & pready_q & ~pwrite;

   // read mux
   always_comb begin
      rd_byte = 8'h00;
      if (hit(paddr, `CMPC_CSR_OFS)) begin
         rd_byte[`CMPC_CSR_DIS]     = dis_q;
         rd_byte[`CMPC_CSR_BG]      = bg_q;
         rd_byte[`CMPC_CSR_RES]     = sync2_q;
         rd_byte[`CMPC_CSR_FLAG]    = flag_q;
         rd_byte[`CMPC_CSR_IE]      = ie_q;
         rd_byte[`CMPC_CSR_CAP]     = cap_q;
         rd_byte[`CMPC_CSR_MODE_HI] = mode_q[1];
         rd_byte[`CMPC_CSR_MODE_LO] = mode_q[0];
      end else if (hit(paddr, `CMPC_DIDR_OFS)) begin
         rd_byte[`CMPC_DIDR_NEG] = neg_off_q;
         rd_byte[`CMPC_DIDR_POS] = pos_off_q;
      end else if (hit(paddr, `CMPC_MUXC_OFS)) begin
         rd_byte[`CMPC_MUXC_EN] = mux_en_q;
         rd_byte[`CMPC_MUXC_CH_HI:`CMPC_MUXC_CH_LO] = chan_q;
      end else if (hit(paddr, `CMPC_STAT_OFS)) begin
         rd_byte[`CMPC_STAT_EVT] = stat_q;
      end else if (hit(paddr, `CMPC_MASK_OFS)) begin
         rd_byte[`CMPC_STAT_EVT] = mask_q;
      end
   end

   // bus answer: prepared in the setup cycle so prdata is a flop
   always_comb begin
      pready_d  = 1'b0;
      prdata_d  = prdata_q;
      pslverr_d = 1'b0;
      if (psel && !penable && !pready_q) begin
         pready_d  = 1'b1;
         prdata_d  = {24'h000000, rd_byte};
         pslverr_d = ~mapped;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_q  <= 32'h00000000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // next values of the registers
   always_comb begin
      dis_d     = dis_q;
      bg_d      = bg_q;
      ie_d      = ie_q;
      cap_d     = cap_q;
      mode_d    = mode_q;
      pos_off_d = pos_off_q;
      neg_off_d = neg_off_q;
      mux_en_d  = mux_en_q;
      chan_d    = chan_q;
      mask_d    = mask_q;
      flag_d    = flag_q;
      stat_d    = stat_q;

      if (wr_en && hit(paddr, `CMPC_CSR_OFS)) begin
         dis_d  = pwdata[`CMPC_CSR_DIS];
         bg_d   = pwdata[`CMPC_CSR_BG];
         ie_d   = pwdata[`CMPC_CSR_IE];
         cap_d  = pwdata[`CMPC_CSR_CAP];
         mode_d = cmpc_mode_e'(pwdata[`CMPC_CSR_MODE_HI:`CMPC_CSR_MODE_LO]);
         if (pwdata[`CMPC_CSR_FLAG]) begin
            flag_d = 1'b0;
         end
      end
      if (wr_en && hit(paddr, `CMPC_DIDR_OFS)) begin
         neg_off_d = pwdata[`CMPC_DIDR_NEG];
         pos_off_d = pwdata[`CMPC_DIDR_POS];
      end
      if (wr_en && hit(paddr, `CMPC_MUXC_OFS)) begin
         mux_en_d = pwdata[`CMPC_MUXC_EN];
         chan_d   = pwdata[`CMPC_MUXC_CH_HI:`CMPC_MUXC_CH_LO];
      end
      if (wr_en && hit(paddr, `CMPC_MASK_OFS)) begin
         mask_d = pwdata[`CMPC_STAT_EVT];
      end
      if (irq_vector_ack) begin
         flag_d = 1'b0;
      end
      // clear only what the read returned; a later event must survive
      if (rd_done && hit(paddr, `CMPC_STAT_OFS) &&
          prdata_q[`CMPC_STAT_EVT]) begin
         stat_d = 1'b0;
      end
      // a new event beats any clear in the same cycle
      if (event_hit) begin
         flag_d = 1'b1;
         stat_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dis_q     <= 1'(`CMPC_CSR_RST >> `CMPC_CSR_DIS);
         bg_q      <= 1'b0;
         flag_q    <= 1'b0;
         ie_q      <= 1'b0;
         cap_q     <= 1'b0;
         mode_q    <= CMPC_TOGGLE;
         pos_off_q <= 1'b0;
         neg_off_q <= 1'b0;
         mux_en_q  <= 1'b0;
         chan_q    <= 3'h0;
         stat_q    <= 1'b0;
         mask_q    <= 1'b0;
      end else begin
         dis_q     <= dis_d;
         bg_q      <= bg_d;
         flag_q    <= flag_d;
         ie_q      <= ie_d;
         cap_q     <= cap_d;
         mode_q    <= mode_d;
         pos_off_q <= pos_off_d;
         neg_off_q <= neg_off_d;
         mux_en_q  <= mux_en_d;
         chan_q    <= chan_d;
         stat_q    <= stat_d;
         mask_q    <= mask_d;
      end
   end

   // outputs registered so every port comes straight from a flop
   always_comb begin
      // mux path only with converter off
      neg_mux_d = mux_en_q & ~converter_enable;
      capture_d = cap_q & sync2_q;
      req_d     = flag_q & ie_q & global_irq_enable;
      irq_d     = stat_q & mask_q;
      pos_rd_d  = pos_pin_digital & ~pos_off_q;
      neg_rd_d  = neg_pin_digital & ~neg_off_q;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         neg_mux_q <= 1'b0;
         capture_q <= 1'b0;
         req_q     <= 1'b0;
         irq_q     <= 1'b0;
         pos_rd_q  <= 1'b0;
         neg_rd_q  <= 1'b0;
      end else begin
         neg_mux_q <= neg_mux_d;
         capture_q <= capture_d;
         req_q     <= req_d;
         irq_q     <= irq_d;
         pos_rd_q  <= pos_rd_d;
         neg_rd_q  <= neg_rd_d;
      end
   end

   assign prdata             = prdata_q;
   assign pready             = pready_q;
   assign pslverr            = pslverr_q;
   assign cmp_power_off      = dis_q;
   assign pos_bandgap_sel    = bg_q;
   assign neg_from_mux       = neg_mux_q;
   // analog mux decodes this as converter pin 0..7
   assign neg_channel_sel    = chan_q;
   assign capture_in         = capture_q;
   assign cmp_irq_req        = req_q;
   assign irq                = irq_q;
   assign pos_pin_buffer_off = pos_off_q;
   assign neg_pin_buffer_off = neg_off_q;
   assign pos_pin_read       = pos_rd_q;
   assign neg_pin_read       = neg_rd_q;

endmodule // cmpc_ctrl

// ===== cmpc_ctrl_chk.sv
`timescale 1ns/10ps
module cmpc_ctrl_chk (
   input wire logic       core_clk,
   input wire logic       reset_n,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       cmp_raw,
   input wire logic       converter_enable,
   input wire logic       global_irq_enable,
   input wire logic       irq_vector_ack,
   input wire logic       neg_from_mux,
   input wire logic       capture_in,
   input wire logic       cmp_irq_req,
   input wire logic       pos_pin_buffer_off,
   input wire logic       neg_pin_buffer_off,
   input wire logic       pos_pin_read,
   input wire logic       neg_pin_read
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_setup;
      psel && !penable;
   endsequence
   // four quiet samples: nothing left in the synchronizer
   sequence s_quiet_ack;
      $stable(cmp_raw) [*4] ##0 irq_vector_ack;
   endsequence
   a_mux_blocked: assert property ($past(converter_enable) |-> !neg_from_mux)
      else $error("mux path active while converter on");
   a_req_gated: assert property (cmp_irq_req |-> $past(global_irq_enable))
      else $error("request without global enable");
   a_pos_read_off: assert property (
      pos_pin_buffer_off && $past(pos_pin_buffer_off) |-> !pos_pin_read)
      else $error("positive pin reads one while buffer off");
   a_neg_read_off: assert property (
      neg_pin_buffer_off && $past(neg_pin_buffer_off) |-> !neg_pin_read)
      else $error("negative pin reads one while buffer off");
   a_capture_sync: assert property (
      capture_in |-> $past(cmp_raw, 2) || $past(cmp_raw, 3))
      else $error("capture input not the synced result");
   a_ack_clears: assert property (s_quiet_ack |-> ##[1:2] !cmp_irq_req)
      else $error("request stays after vector ack");
   a_ready_after: assert property (s_setup |=> pready)
      else $error("no ready in first access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_unmapped: assert property (pready && paddr > 8'h13 |-> pslverr)
      else $error("no error on unmapped address");
endmodule // cmpc_ctrl_chk

// ===== cmpc_defs.svh
`ifndef CMPC_DEFS_SVH
`define CMPC_DEFS_SVH

// register byte offsets
`define CMPC_CSR_OFS     8'h00
`define CMPC_DIDR_OFS    8'h04
`define CMPC_MUXC_OFS    8'h08
`define CMPC_STAT_OFS    8'h0c
`define CMPC_MASK_OFS    8'h10

// comparator_control_status fields
`define CMPC_CSR_DIS     7
`define CMPC_CSR_BG      6
`define CMPC_CSR_RES     5
`define CMPC_CSR_FLAG    4
`define CMPC_CSR_IE      3
`define CMPC_CSR_CAP     2
`define CMPC_CSR_MODE_HI 1
`define CMPC_CSR_MODE_LO 0

// comparator_pin_input_disable fields
`define CMPC_DIDR_NEG    1
`define CMPC_DIDR_POS    0

// mux control fields
`define CMPC_MUXC_EN     6
`define CMPC_MUXC_CH_HI  2
`define CMPC_MUXC_CH_LO  0

// status / mask fields
`define CMPC_STAT_EVT    0

// reset values
`define CMPC_CSR_RST     8'h00
`define CMPC_DIDR_RST    8'h00
`define CMPC_MUXC_RST    8'h00
`define CMPC_STAT_RST    8'h00
`define CMPC_MASK_RST    8'h00

`endif

// ===== cmpc_pkg.sv
package cmpc_pkg;

   // event that raises the comparator flag
   typedef enum logic [1:0] {
      CMPC_TOGGLE,
      CMPC_RESERVED,
      CMPC_FALL,
      CMPC_RISE
   } cmpc_mode_e;

   typedef logic [7:0] cmpc_byte_t;

endpackage

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
   logic        core_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        cmp_raw = 1'b0, converter_enable = 1'b0, irq_vector_ack = 1'b0;
   logic        global_irq_enable = 1'b0, pos_pin_digital = 1'b1;
   logic        neg_pin_digital = 1'b1, pready, pslverr, perr, irq;
   logic [3:0]  pstrb = 4'hf;
   logic        cmp_power_off, pos_bandgap_sel, neg_from_mux, capture_in;
   logic        cmp_irq_req, pos_pin_buffer_off, neg_pin_buffer_off;
   logic        pos_pin_read, neg_pin_read;
   logic [2:0]  neg_channel_sel;
   int          err_total = 0, checked = 0;
   always #4 core_clk = ~core_clk;
   cmpc_ctrl dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmp_raw(cmp_raw), .converter_enable(converter_enable),
      .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
      .pos_pin_digital(pos_pin_digital), .neg_pin_digital(neg_pin_digital),
      .cmp_power_off(cmp_power_off), .pos_bandgap_sel(pos_bandgap_sel),
      .neg_from_mux(neg_from_mux), .neg_channel_sel(neg_channel_sel),
      .capture_in(capture_in), .cmp_irq_req(cmp_irq_req), .irq(irq),
      .pos_pin_buffer_off(pos_pin_buffer_off),
      .neg_pin_buffer_off(neg_pin_buffer_off),
      .pos_pin_read(pos_pin_read), .neg_pin_read(neg_pin_read));
   task automatic close_out();
      if (err_total == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge core_clk);
   endtask
   // idle cycle first so psel never gets two drives in one step
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 9);
      if (pready !== 1'b1) begin
         err_total++;
         close_out();
      end
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(logic [7:0] a, logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, q);
   endtask
   initial begin
      tick(3);
      reset_n <= 1'b1;
      for (int i = 0; i < 5; i++)
         rdc(8'(4 * i), 32'h0);
      rdc(8'h20, 32'h0);
      chk("slverr", 32'h1, 32'(perr));
      xfer(1'b1, 8'h00, 32'he7);
      rdc(8'h00, 32'hc7);
      chk("power_off", 32'h1, 32'(cmp_power_off));
      chk("bandgap", 32'h1, 32'(pos_bandgap_sel));
      xfer(1'b1, 8'h04, 32'hff);
      rdc(8'h04, 32'h3);
      chk("pos_off", 32'h1, 32'(pos_pin_buffer_off));
      chk("neg_off", 32'h1, 32'(neg_pin_buffer_off));
      chk("pos_read", 32'h0, 32'(pos_pin_read));
      chk("neg_read", 32'h0, 32'(neg_pin_read));
      xfer(1'b1, 8'h04, 32'h0);
      tick(3);
      chk("pos_read", 32'h1, 32'(pos_pin_read));
      chk("neg_read", 32'h1, 32'(neg_pin_read));
      pstrb <= 4'h0;
      xfer(1'b1, 8'h04, 32'h3);
      pstrb <= 4'hf;
      rdc(8'h04, 32'h0);
      for (int c = 0; c < 8; c++) begin
         xfer(1'b1, 8'h08, 32'h40 | 32'(c));
         tick(2);
         chk("channel", 32'(c), 32'(neg_channel_sel));
         chk("from_mux", 32'h1, 32'(neg_from_mux));
      end
      converter_enable <= 1'b1;
      tick(3);
      chk("from_mux", 32'h0, 32'(neg_from_mux));
      converter_enable <= 1'b0;
      xfer(1'b1, 8'h08, 32'h07);
      tick(2);
      chk("from_mux", 32'h0, 32'(neg_from_mux));
      xfer(1'b1, 8'h10, 32'h1);
      for (int m = 0; m < 4; m++) begin
         xfer(1'b1, 8'h00, 32'h10 | 32'(m));
         cmp_raw <= 1'b1;
         tick(5);
         rdc(8'h00, 32'h20 | 32'(m) | ((m == 0 || m == 3) ? 32'h10 : 32'h0));
         xfer(1'b1, 8'h00, 32'h10 | 32'(m));
         cmp_raw <= 1'b0;
         tick(5);
         rdc(8'h00, 32'(m) | ((m == 0 || m == 2) ? 32'h10 : 32'h0));
      end
      chk("irq", 32'h1, 32'(irq));
      rdc(8'h0c, 32'h1);
      tick(2);
      chk("irq", 32'h0, 32'(irq));
      xfer(1'b1, 8'h00, 32'h1b);
      global_irq_enable <= 1'b1;
      cmp_raw <= 1'b1;
      tick(6);
      chk("irq_req", 32'h1, 32'(cmp_irq_req));
      irq_vector_ack <= 1'b1;
      tick(1);
      irq_vector_ack <= 1'b0;
      tick(3);
      chk("irq_req", 32'h0, 32'(cmp_irq_req));
      rdc(8'h00, 32'h2b);
      cmp_raw <= 1'b0;
      global_irq_enable <= 1'b0;
      tick(4);
      cmp_raw <= 1'b1;
      tick(6);
      chk("irq_req", 32'h0, 32'(cmp_irq_req));
      xfer(1'b1, 8'h00, 32'h2b);
      rdc(8'h00, 32'h3b);
      xfer(1'b1, 8'h00, 32'h3f);
      rdc(8'h00, 32'h2f);
      tick(3);
      chk("capture", 32'h1, 32'(capture_in));
      // capture irq enable sits in the timer, not here
      xfer(1'b1, 8'h00, 32'h3);
      tick(3);
      chk("capture", 32'h0, 32'(capture_in));
      xfer(1'b1, 8'h00, 32'h0);
      xfer(1'b1, 8'h10, 32'h0);
      rdc(8'h0c, 32'h1);
      cmp_raw <= 1'b0;
      tick(6);
      chk("irq", 32'h0, 32'(irq));
      rdc(8'h0c, 32'h1);
      xfer(1'b1, 8'h20, 32'hff);
      chk("slverr", 32'h1, 32'(perr));
      close_out();
   end
endmodule // testbench
bind cmpc_ctrl cmpc_ctrl_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .cmp_raw(cmp_raw), .converter_enable(converter_enable),
   .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
   .neg_from_mux(neg_from_mux), .capture_in(capture_in),
   .cmp_irq_req(cmp_irq_req), .pos_pin_buffer_off(pos_pin_buffer_off),
   .neg_pin_buffer_off(neg_pin_buffer_off), .pos_pin_read(pos_pin_read),
   .neg_pin_read(neg_pin_read));
